// file: uimr_top.sv
// Operation
// - class-0 enable bit 31 gates the fault-isolation interrupt.
// - class-0 enable bit 61 gates the unit-error interrupt.
// - class-0 enable bit 62 gates the invalid DMA command interrupt.
// - class-0 enable bit 63 gates the misaligned DMA interrupt.
// - unit-error enable bit 63 lets invalid instructions set class-0 pending bit 61.
// - illegal-operation detection and unit halting always stay active.
// - class-1 enable bit 60 gates the put address-compare suspend interrupt.
// - class-1 enable bit 61 gates the get address-compare suspend interrupt.
// - class-1 enable bit 62 gates the mapping-fault storage interrupt.
// - class-1 enable bit 63 gates the segment-fault interrupt.
// - class-2 enable bit 59 gates the mailbox threshold interrupt.
// - class-2 enable bit 60 gates the tag group completion interrupt.
// - class-2 enable bit 61 gates the halt trap or single-step interrupt.
// - class-2 enable bit 62 gates the stop-and-signal trap interrupt.
// - class-2 enable bit 63 gates the general mailbox interrupt.
// - each class has a pending register laid out like its enable register.
// - a pending bit at one means that interrupt is pending.
// - routing priority fields sit at bits 0:3, 16:19 and 32:35.
// - routing destination fields sit at bits 8:15, 24:31 and 40:47.
// - priority zero is highest, fifteen is lowest.
// - destination upper nibble is bus node, lower nibble is target unit.
// - unit codes 0 and B are io controllers, E and F threads.
`default_nettype none
`include "uimr_defines.svh"

module uimr_top
   import uimr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`UIMR_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`UIMR_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ev_fault_isolation,
   input wire logic ev_dma_cmd_invalid,
   input wire logic ev_dma_misaligned,
   input wire logic ev_illegal_insn,
   input wire logic ev_put_compare,
   input wire logic ev_get_compare,
   input wire logic ev_mapping_fault,
   input wire logic ev_segment_fault,
   input wire logic ev_mbox_threshold,
   input wire logic ev_tag_group_done,
   input wire logic ev_halt_or_step,
   input wire logic ev_stop_signal,
   input wire logic ev_mailbox,
   input wire logic unit_resume,
   output logic unit_halt,
   output logic irq_valid,
   input wire logic irq_ready,
   output logic [1:0] irq_class,
   output logic [3:0] irq_prio,
   output logic [3:0] irq_node,
   output logic [3:0] irq_unit,
   output logic tgt_io_zero,
   output logic tgt_io_one,
   output logic tgt_thread0,
   output logic tgt_thread1
);

   // ***************************************************************
   // state
   // ***************************************************************
   uimr_state_t q;
   uimr_state_t d;
   logic [2:0] active;
   logic [0:63] set0;
   logic [0:63] set1;
   logic [0:63] set2;
   logic [0:63] gate [`UIMR_NCLASS];

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [0:63] reg_of(input uimr_state_t s, input logic [`UIMR_AW-1:0] a);
      logic [0:63] r;
      r = '0;
      unique case ({a[`UIMR_AW-1:`UIMR_REG_SEL_LO], 3'h0})
         `UIMR_OFF_EN0: r = s.en0;
         `UIMR_OFF_UERR: r = s.uerr;
         `UIMR_OFF_EN1: r = s.en1;
         `UIMR_OFF_EN2: r = s.en2;
         `UIMR_OFF_PEND0: r = s.pend0;
         `UIMR_OFF_PEND1: r = s.pend1;
         `UIMR_OFF_PEND2: r = s.pend2;
         `UIMR_OFF_ROUTE: r = s.route;
         default: r = '0;
      endcase
      return r;
   endfunction : reg_of

   function automatic logic mapped(input logic [`UIMR_AW-1:0] a);
      return a[`UIMR_DECODE_MSB:`UIMR_DECODE_LSB] == '0;
   endfunction : mapped

   function automatic logic [3:0] prio_of(input logic [0:63] rt, input int c);
      logic [3:0] p;
      p = rt[`UIMR_RT_PRIO0 +: 4];
      if (c == 1) begin
         p = rt[`UIMR_RT_PRIO1 +: 4];
      end else if (c == 2) begin
         p = rt[`UIMR_RT_PRIO2 +: 4];
      end
      return p;
   endfunction : prio_of

   function automatic logic [7:0] dest_of(input logic [0:63] rt, input int c);
      logic [7:0] v;
      v = rt[`UIMR_RT_DEST0 +: 8];
      if (c == 1) begin
         v = rt[`UIMR_RT_DEST1 +: 8];
      end else if (c == 2) begin
         v = rt[`UIMR_RT_DEST2 +: 8];
      end
      return v;
   endfunction : dest_of

   // ***************************************************************
   // event capture into pending vectors
   // ***************************************************************
   always_comb begin
      set0 = '0;
      set1 = '0;
      set2 = '0;
      set0[`UIMR_C0_FIR] = ev_fault_isolation;
      set0[`UIMR_C0_DCMD] = ev_dma_cmd_invalid;
      set0[`UIMR_C0_ALIGN] = ev_dma_misaligned;
      set0[`UIMR_C0_UERR] = ev_illegal_insn & q.uerr[`UIMR_UERR_INV];
      set1[`UIMR_C1_PUT] = ev_put_compare;
      set1[`UIMR_C1_GET] = ev_get_compare;
      set1[`UIMR_C1_MAP] = ev_mapping_fault;
      set1[`UIMR_C1_SEG] = ev_segment_fault;
      set2[`UIMR_C2_MBTH] = ev_mbox_threshold;
      set2[`UIMR_C2_TAG] = ev_tag_group_done;
      set2[`UIMR_C2_HALT] = ev_halt_or_step;
      set2[`UIMR_C2_STOP] = ev_stop_signal;
      set2[`UIMR_C2_MBOX] = ev_mailbox;
   end

   // ***************************************************************
   // per-class gating: pending and enable share positions
   // ***************************************************************
   assign gate[0] = q.pend0 & q.en0 & `UIMR_MASK_C0;
   assign gate[1] = q.pend1 & q.en1 & `UIMR_MASK_C1;
   assign gate[2] = q.pend2 & q.en2 & `UIMR_MASK_C2;

   genvar gc;
   generate
      for (gc = 0; gc < `UIMR_NCLASS; gc++) begin : g_class
         assign active[gc] = |gate[gc];
      end
   endgenerate

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      logic [31:0] bm;
      logic [0:63] wm;
      logic [0:63] wd;
      logic [0:63] rr;
      logic [0:63] clr0;
      logic [0:63] clr1;
      logic [0:63] clr2;
      logic found;
      logic [3:0] bp;
      logic [1:0] bc;
      logic [7:0] dst;
      bm = '0;
      wm = '0;
      wd = '0;
      rr = '0;
      clr0 = '0;
      clr1 = '0;
      clr2 = '0;
      found = 1'b0;
      bp = '0;
      bc = '0;
      dst = '0;
      d = q;

      // write address and data are taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      if (q.aw_got && q.w_got) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = mapped(q.awaddr) ? `UIMR_RESP_OKAY : `UIMR_RESP_SLVERR;
         for (int i = 0; i < 4; i++) begin
            bm[i*8 +: 8] = {8{q.wstrb[i]}};
         end
         // low address word carries bits 0:31, the upper half of the value
         wm = q.awaddr[`UIMR_HALF_BIT] ? {32'h0, bm} : {bm, 32'h0};
         wd = q.awaddr[`UIMR_HALF_BIT] ? {32'h0, q.wdata} : {q.wdata, 32'h0};
         if (mapped(q.awaddr)) begin
            unique case ({q.awaddr[`UIMR_AW-1:`UIMR_REG_SEL_LO], 3'h0})
               `UIMR_OFF_EN0: d.en0 = ((q.en0 & ~wm) | (wd & wm)) & `UIMR_MASK_C0;
               `UIMR_OFF_UERR: d.uerr = ((q.uerr & ~wm) | (wd & wm)) & `UIMR_MASK_UERR;
               `UIMR_OFF_EN1: d.en1 = ((q.en1 & ~wm) | (wd & wm)) & `UIMR_MASK_C1;
               `UIMR_OFF_EN2: d.en2 = ((q.en2 & ~wm) | (wd & wm)) & `UIMR_MASK_C2;
               `UIMR_OFF_PEND0: clr0 = wd & wm;
               `UIMR_OFF_PEND1: clr1 = wd & wm;
               `UIMR_OFF_PEND2: clr2 = wd & wm;
               `UIMR_OFF_ROUTE: d.route = ((q.route & ~wm) | (wd & wm)) & `UIMR_MASK_ROUTE;
               default: d.route = q.route;
            endcase
         end
      end

      // pending: write one to clear, a same-cycle event wins
      d.pend0 = ((q.pend0 & ~clr0) | set0) & `UIMR_MASK_C0;
      d.pend1 = ((q.pend1 & ~clr1) | set1) & `UIMR_MASK_C1;
      d.pend2 = ((q.pend2 & ~clr2) | set2) & `UIMR_MASK_C2;

      // read path, answer one cycle after the address is taken
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rr = reg_of(q, s_axi_araddr);
         d.rvalid = 1'b1;
         d.rdata = s_axi_araddr[`UIMR_HALF_BIT] ? rr[32:63] : rr[0:31];
         d.rresp = `UIMR_RESP_OKAY;
         if (!mapped(s_axi_araddr)) begin
            d.rdata = '0;
            d.rresp = `UIMR_RESP_SLVERR;
         end
      end

      // halting does not depend on the invalid-instruction enable
      if (ev_illegal_insn) begin
         d.halted = 1'b1;
      end else if (unit_resume) begin
         d.halted = 1'b0;
      end

      // a class sends one packet per assertion; re-armed when it drops
      for (int c = 0; c < `UIMR_NCLASS; c++) begin
         if (!active[c]) begin
            d.sent[c] = 1'b0;
         end
      end

      unique case (q.fsm)
         UIMR_IDLE: begin
            for (int c = 0; c < `UIMR_NCLASS; c++) begin
               // strictly lower value wins, ties go to the lower class
               if (active[c] && !q.sent[c] && (!found || prio_of(q.route, c) < bp)) begin
                  found = 1'b1;
                  bp = prio_of(q.route, c);
                  bc = 2'(c);
               end
            end
            if (found) begin
               dst = dest_of(q.route, int'(bc));
               d.fsm = UIMR_SEND;
               d.pk_class = bc;
               d.pk_prio = bp;
               d.pk_node = dst[7:4];
               d.pk_unit = dst[3:0];
               d.pk_tgt = {dst[3:0] == `UIMR_UNIT_THREAD1, dst[3:0] == `UIMR_UNIT_THREAD0,
                           dst[3:0] == `UIMR_UNIT_IO_ONE, dst[3:0] == `UIMR_UNIT_IO_ZERO};
            end
         end
         UIMR_SEND: begin
            // packet is committed even if the class drops meanwhile
            if (irq_ready) begin
               d.fsm = UIMR_IDLE;
               d.sent[q.pk_class] = active[q.pk_class];
            end
         end
      endcase
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign s_axi_awready = !q.aw_got && !q.bvalid;
   assign s_axi_wready = !q.w_got && !q.bvalid;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign unit_halt = q.halted;
   assign irq_valid = (q.fsm == UIMR_SEND);
   assign irq_class = q.pk_class;
   assign irq_prio = q.pk_prio;
   assign irq_node = q.pk_node;
   assign irq_unit = q.pk_unit;
   assign tgt_io_zero = q.pk_tgt[0];
   assign tgt_io_one = q.pk_tgt[1];
   assign tgt_thread0 = q.pk_tgt[2];
   assign tgt_thread1 = q.pk_tgt[3];

endmodule : uimr_top

`default_nettype wire

// file: uimr_defines.svh
`ifndef UIMR_DEFINES_SVH
`define UIMR_DEFINES_SVH

// ***************************************************************
// bus geometry and register offsets (two aligned words per register)
// ***************************************************************
`define UIMR_AW 12
`define UIMR_OFF_EN0 12'h000
`define UIMR_OFF_UERR 12'h008
`define UIMR_OFF_EN1 12'h010
`define UIMR_OFF_EN2 12'h018
`define UIMR_OFF_PEND0 12'h020
`define UIMR_OFF_PEND1 12'h028
`define UIMR_OFF_PEND2 12'h030
`define UIMR_OFF_ROUTE 12'h038
`define UIMR_REG_SEL_HI 5
`define UIMR_REG_SEL_LO 3
`define UIMR_HALF_BIT 2
`define UIMR_DECODE_MSB 11
`define UIMR_DECODE_LSB 6
`define UIMR_RESP_OKAY 2'h0
`define UIMR_RESP_SLVERR 2'h2

// ***************************************************************
// bit positions, ascending numbering: bit 0 is the msb of 64
// ***************************************************************
`define UIMR_C0_FIR 31
`define UIMR_C0_UERR 61
`define UIMR_C0_DCMD 62
`define UIMR_C0_ALIGN 63
`define UIMR_C1_PUT 60
`define UIMR_C1_GET 61
`define UIMR_C1_MAP 62
`define UIMR_C1_SEG 63
`define UIMR_C2_MBTH 59
`define UIMR_C2_TAG 60
`define UIMR_C2_HALT 61
`define UIMR_C2_STOP 62
`define UIMR_C2_MBOX 63
`define UIMR_UERR_INV 63
`define UIMR_RT_PRIO0 0
`define UIMR_RT_DEST0 8
`define UIMR_RT_PRIO1 16
`define UIMR_RT_DEST1 24
`define UIMR_RT_PRIO2 32
`define UIMR_RT_DEST2 40

// ***************************************************************
// implemented-bit masks and target unit codes
// ***************************************************************
`define UIMR_MASK_C0 64'h0000_0001_0000_0007
`define UIMR_MASK_C1 64'h0000_0000_0000_000f
`define UIMR_MASK_C2 64'h0000_0000_0000_001f
`define UIMR_MASK_UERR 64'h0000_0000_0000_0001
`define UIMR_MASK_ROUTE 64'hf0ff_f0ff_f0ff_0000
`define UIMR_UNIT_IO_ZERO 4'h0
`define UIMR_UNIT_IO_ONE 4'hb
`define UIMR_UNIT_THREAD0 4'he
`define UIMR_UNIT_THREAD1 4'hf
`define UIMR_NCLASS 3

`endif

// file: uimr_pkg.sv
`default_nettype none
`include "uimr_defines.svh"

package uimr_pkg;

   typedef enum logic {UIMR_IDLE, UIMR_SEND} uimr_fsm_t;

   typedef struct packed {
      logic [0:63] en0;
      logic [0:63] uerr;
      logic [0:63] en1;
      logic [0:63] en2;
      logic [0:63] pend0;
      logic [0:63] pend1;
      logic [0:63] pend2;
      logic [0:63] route;
      logic aw_got;
      logic [`UIMR_AW-1:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic halted;
      uimr_fsm_t fsm;
      logic [2:0] sent;
      logic [1:0] pk_class;
      logic [3:0] pk_prio;
      logic [3:0] pk_node;
      logic [3:0] pk_unit;
      logic [3:0] pk_tgt;
   } uimr_state_t;

endpackage : uimr_pkg

`default_nettype wire

// file: uimr_props.sv
`default_nettype none
`include "uimr_defines.svh"

module uimr_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`UIMR_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic ev_illegal_insn,
   input wire logic unit_resume,
   input wire logic unit_halt,
   input wire logic irq_valid,
   input wire logic irq_ready,
   input wire logic [1:0] irq_class,
   input wire logic [3:0] irq_prio,
   input wire logic [3:0] irq_node,
   input wire logic [3:0] irq_unit,
   input wire logic tgt_io_zero,
   input wire logic tgt_io_one,
   input wire logic tgt_thread0,
   input wire logic tgt_thread1
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************************
   // port relations
   // ***************************************************************
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_halt_on_illegal: assert property (ev_illegal_insn |=> unit_halt)
      else $error("no halt after illegal operation");
   a_halt_holds: assert property (unit_halt && !unit_resume |=> unit_halt)
      else $error("halt dropped without resume");
   a_halt_release: assert property (unit_resume && !ev_illegal_insn |=> !unit_halt)
      else $error("halt kept after resume");
   a_pkt_hold: assert property (irq_valid && !irq_ready |=>
      irq_valid && $stable({irq_class, irq_prio, irq_node, irq_unit}))
      else $error("packet changed before accept");
   a_pkt_gap: assert property (irq_valid && irq_ready |=> !irq_valid)
      else $error("no idle cycle after packet");
   a_tgt_decode: assert property (irq_valid |-> {tgt_io_zero, tgt_io_one, tgt_thread0, tgt_thread1} ==
      {irq_unit == 4'h0, irq_unit == 4'hb, irq_unit == 4'he, irq_unit == 4'hf})
      else $error("target decode wrong");
   a_class_legal: assert property (irq_valid |-> irq_class != 2'h3)
      else $error("class code out of range");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && (|s_axi_araddr[11:6]) |=>
      s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_rd_mapped: assert property (s_axi_arvalid && s_axi_arready && !(|s_axi_araddr[11:6]) |=>
      s_axi_rvalid && s_axi_rresp == 2'h0)
      else $error("mapped read refused");
endmodule : uimr_props

bind uimr_top uimr_props i_uimr_props (.*);

`default_nettype wire

// file: uimr_irq_sink.sv
`default_nettype none

module uimr_irq_sink (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_valid,
   input wire logic [3:0] stall,
   output logic irq_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_q;

   // ***************************************************************
   // receiver: accepts after stall cycles, slow answers test the hold
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_q <= 4'h0;
         irq_ready <= 1'b0;
      end else begin
         irq_ready <= irq_valid && !irq_ready && wait_q >= stall;
         wait_q <= (irq_valid && !irq_ready) ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule : uimr_irq_sink

`default_nettype wire

// file: tb_unit_interrupt_mask_route.sv
`default_nettype none
`include "uimr_defines.svh"

module tb_unit_interrupt_mask_route;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [`UIMR_AW-1:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, irq_prio, irq_node, irq_unit, stall = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, unit_resume = 1'b0;
   logic unit_halt, irq_valid, irq_ready, tgt_io_zero, tgt_io_one, tgt_thread0, tgt_thread1;
   logic [1:0] s_axi_bresp, s_axi_rresp, irq_class;
   logic [12:0] ev = 13'h0;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   int pos [13] = '{31, 62, 63, 61, 60, 61, 62, 63, 59, 60, 61, 62, 63};
   logic [11:0] eb [3] = '{12'h000, 12'h010, 12'h018}, pb [3] = '{12'h020, 12'h028, 12'h030};
   logic [11:0] wa [10] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h038, 12'h03c};
   logic [31:0] we [10] = '{32'h1, 32'h7, 32'h0, 32'h1, 32'h0, 32'hf, 32'h0, 32'h1f, 32'hf0fff0ff, 32'hf0ff0000};
   logic [3:0] pr [3] = '{4'h3, 4'h0, 4'hf};
   logic [7:0] ds [3] = '{8'h5e, 8'ha0, 8'h7b};

   uimr_top i_uimr_top (.*, .ev_fault_isolation(ev[0]), .ev_dma_cmd_invalid(ev[1]), .ev_dma_misaligned(ev[2]),
      .ev_illegal_insn(ev[3]), .ev_put_compare(ev[4]), .ev_get_compare(ev[5]), .ev_mapping_fault(ev[6]),
      .ev_segment_fault(ev[7]), .ev_mbox_threshold(ev[8]), .ev_tag_group_done(ev[9]),
      .ev_halt_or_step(ev[10]), .ev_stop_signal(ev[11]), .ev_mailbox(ev[12]));
   uimr_irq_sink i_uimr_irq_sink (.aclk(aclk), .aresetn(aresetn), .irq_valid(irq_valid), .stall(stall),
      .irq_ready(irq_ready));

   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 10000) begin
         err("timeout");
         final_report();
      end
   end
   // ***************************************************************
   // bus and compare tasks
   // ***************************************************************
   task automatic err(input string m);
      n_mismatch++;
      $display("ERROR at %0t: %s", $time, m);
   endtask : err
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) err($sformatf("%s got %h exp %h", m, got, exp));
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
            return;
         end
      end
      err("write hung");
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            chk(s_axi_rdata, exp, "rdata");
            chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
            return;
         end
      end
      err("read hung");
   endtask : rd
   task automatic pkt(input logic [1:0] c, input logic [3:0] p, input logic [7:0] d);
      for (int i = 0; i < 40 && irq_valid !== 1'b1; i++) @(posedge aclk);
      chk({18'h0, irq_class, irq_prio, irq_node, irq_unit}, {18'h0, c, p, d}, "packet");
      chk({28'h0, tgt_io_zero, tgt_io_one, tgt_thread0, tgt_thread1},
         {28'h0, d[3:0] == 4'h0, d[3:0] == 4'hb, d[3:0] == 4'he, d[3:0] == 4'hf}, "target");
      for (int i = 0; i < 40 && !(irq_valid === 1'b1 && irq_ready === 1'b1); i++) @(posedge aclk);
      @(posedge aclk);
   endtask : pkt
   task automatic final_report;
      $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   // ***************************************************************
   // tests
   // ***************************************************************
   initial begin
      int c;
      logic [11:0] ea, pa;
      logic [31:0] m;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      wr(12'h040, 32'hffff_ffff, 2'h2);
      rd(12'h044, 32'h0, 2'h2);
      for (int a = 0; a < 64; a += 4) rd(a[11:0], 32'h0, 2'h0);
      for (int k = 0; k < 10; k++) begin
         wr(wa[k], 32'hffff_ffff, 2'h0);
         rd(wa[k], we[k], 2'h0);
         wr(wa[k], 32'h0, 2'h0);
      end
      // byte strobes: only the lowest byte of the high routing word lands
      s_axi_wstrb <= 4'h1;
      wr(12'h038, 32'hffff_ffff, 2'h0);
      s_axi_wstrb <= 4'hf;
      rd(12'h038, 32'h0000_00ff, 2'h0);
      wr(12'h038, 32'h0, 2'h0);
      // all events at once with every enable off
      ev <= 13'h1fff;
      @(posedge aclk);
      ev <= 13'h0;
      repeat (3) @(posedge aclk);
      chk({30'h0, unit_halt, irq_valid}, 32'h2, "halt without irq");
      rd(12'h020, 32'h1, 2'h0);
      rd(12'h024, 32'h3, 2'h0);
      rd(12'h02c, 32'hf, 2'h0);
      rd(12'h034, 32'h1f, 2'h0);
      unit_resume <= 1'b1;
      for (int a = 32; a < 56; a += 4) wr(a[11:0], 32'hffff_ffff, 2'h0);
      unit_resume <= 1'b0;
      for (int a = 32; a < 56; a += 4) rd(a[11:0], 32'h0, 2'h0);
      chk({31'h0, unit_halt}, 32'h0, "halt released");
      wr(12'h00c, 32'h1, 2'h0);
      ev <= 13'h8;
      @(posedge aclk);
      ev <= 13'h0;
      rd(12'h024, 32'h4, 2'h0);
      wr(12'h024, 32'h4, 2'h0);
      // each source: gated first, then delivered
      wr(12'h038, 32'h305e00a0, 2'h0);
      wr(12'h03c, 32'hf07b0000, 2'h0);
      for (int i = 0; i < 13; i++) begin
         c = (i < 4) ? 0 : (i < 8) ? 1 : 2;
         ea = eb[c] + ((pos[i] < 32) ? 12'h000 : 12'h004);
         pa = pb[c] + ((pos[i] < 32) ? 12'h000 : 12'h004);
         m = 32'h1 << (31 - pos[i] % 32);
         wr(ea, ~m, 2'h0);
         ev <= 13'h1 << i;
         @(posedge aclk);
         ev <= 13'h0;
         repeat (4) @(posedge aclk);
         chk({31'h0, irq_valid}, 32'h0, "gated source sent");
         rd(pa, m, 2'h0);
         wr(pa, m, 2'h0);
         wr(ea, m, 2'h0);
         ev <= 13'h1 << i;
         @(posedge aclk);
         ev <= 13'h0;
         pkt(c[1:0], pr[c], ds[c]);
         wr(pa, m, 2'h0);
         wr(ea, 32'h0, 2'h0);
      end
      // three classes at once, slow receiver
      stall <= 4'h3;
      wr(12'h038, 32'h102ff03b, 2'h0);
      wr(12'h03c, 32'h004e0000, 2'h0);
      wr(12'h004, 32'h1, 2'h0);
      wr(12'h014, 32'h1, 2'h0);
      wr(12'h01c, 32'h1, 2'h0);
      ev <= 13'h1084;
      @(posedge aclk);
      ev <= 13'h0;
      pkt(2'h2, 4'h0, 8'h4e);
      pkt(2'h0, 4'h1, 8'h2f);
      pkt(2'h1, 4'hf, 8'h3b);
      final_report();
   end
endmodule : tb_unit_interrupt_mask_route

`default_nettype wire
